//--- rtl/caf_filter.sv
// Purpose: receive acceptance filtering and buffer routing
// Assumes: one clock; message strobe and register strobes synchronous to it
// Notes: routing result is registered one cycle after the strobe, the flag views and irq two cycles after
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "caf_map.svh"

module caf_filter #(
    parameter int NFILT = 16,
    parameter int NBUF = 32
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // register port
    input wire logic [`CAF_ADDR_W-1:0] I_ADDR,
    input wire logic [`CAF_DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [`CAF_DATA_W-1:0] O_RDATA,
    // received message from the protocol engine
    input wire logic I_MSG_VALID,
    input wire caf_pkg::caf_msg_t I_MSG,
    // routing result towards the message ram
    output logic O_ACCEPT,
    output logic O_REJECT,
    output caf_pkg::caf_route_t O_ROUTE,
    // flag views and interrupt
    output logic [NBUF-1:0] O_FULL,
    output logic [NBUF-1:0] O_OVF,
    output logic O_IRQ
);
    import caf_pkg::*;

    logic [15:0] filt_en_q;
    logic [15:0] dest_q [4];
    logic [15:0] msel_q [2];
    logic [15:0] mask_sid_q [3];
    logic [15:0] mask_eid_q [3];
    logic [15:0] filt_sid_q [NFILT];
    logic [15:0] filt_eid_q [NFILT];
    logic [NBUF-1:0] full_q;
    logic [NBUF-1:0] ovf_q;
    logic [`CAF_INT_W-1:0] int_stat_q;
    logic [`CAF_INT_W-1:0] int_en_q;

    // per-filter match
    logic [NFILT-1:0] hit;
    always_comb begin
        for (int f = 0; f < NFILT; f++) begin
            logic [1:0] ms;
            logic [15:0] msid;
            logic [15:0] meid;
            logic sid_ok;
            logic eid_ok;
            logic type_ok;
            ms = msel_q[f/8][(f%8)*2 +: 2];
            msid = 16'h0000;
            meid = 16'h0000;
            sid_ok = 1'b0;
            eid_ok = 1'b0;
            type_ok = 1'b1;
            case (caf_msk_sel_t'(ms))
                CAF_MSK0: begin
                    msid = mask_sid_q[0];
                    meid = mask_eid_q[0];
                end
                CAF_MSK1: begin
                    msid = mask_sid_q[1];
                    meid = mask_eid_q[1];
                end
                CAF_MSK2: begin
                    msid = mask_sid_q[2];
                    meid = mask_eid_q[2];
                end
                default: begin
                    msid = 16'h0000; // reserved code never matches
                    meid = 16'h0000;
                end
            endcase
            sid_ok = ((I_MSG.sid ^ filt_sid_q[f][`CAF_SID_HI:`CAF_SID_LO])
                      & msid[`CAF_SID_HI:`CAF_SID_LO]) == 11'h000;
            eid_ok = ((I_MSG.eid ^ {filt_sid_q[f][1:0], filt_eid_q[f]})
                      & {msid[1:0], meid}) == 18'h00000;
            if (msid[`CAF_TYPE_BIT]) begin
                type_ok = (filt_sid_q[f][`CAF_TYPE_BIT] == I_MSG.ext);
            end else begin
                type_ok = 1'b1;
            end
            // extended bits only take part for extended frames
            hit[f] = filt_en_q[f] && (ms != `CAF_MSK_RSVD) && sid_ok && type_ok
                     && (!I_MSG.ext || eid_ok);
        end
    end

    // lowest-numbered hit wins
    logic any_hit;
    logic [3:0] win;
    logic [3:0] win_dest;
    always_comb begin
        any_hit = 1'b0;
        win = 4'h0;
        for (int f = NFILT - 1; f >= 0; f--) begin
            if (hit[f]) begin
                any_hit = 1'b1;
                win = f[3:0];
            end
        end
        win_dest = dest_q[win[3:2]][win[1:0]*4 +: 4];
    end

    logic to_fifo;
    logic store_buf;
    assign to_fifo = (win_dest == `CAF_DEST_FIFO);
    assign store_buf = I_MSG_VALID && any_hit && !to_fifo;

    logic wr_full0, wr_full1, wr_ovf0, wr_ovf1;
    assign wr_full0 = I_WR && (I_ADDR == `CAF_OFF_FULL0);
    assign wr_full1 = I_WR && (I_ADDR == `CAF_OFF_FULL1);
    assign wr_ovf0 = I_WR && (I_ADDR == `CAF_OFF_OVF0);
    assign wr_ovf1 = I_WR && (I_ADDR == `CAF_OFF_OVF1);

    // full flags: a zero write clears, a store sets and wins
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            full_q <= '0;
        end else begin
            logic [NBUF-1:0] nxt;
            nxt = full_q;
            if (wr_full0) begin
                nxt[15:0] = nxt[15:0] & I_WDATA;
            end
            if (wr_full1) begin
                nxt[31:16] = nxt[31:16] & I_WDATA;
            end
            if (store_buf) begin
                nxt[win_dest] = 1'b1;
            end
            full_q <= nxt;
        end
    end

    // overflow flags
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ovf_q <= '0;
        end else begin
            logic [NBUF-1:0] nxt;
            nxt = ovf_q;
            if (wr_ovf0) begin
                nxt[15:0] = nxt[15:0] & I_WDATA;
            end
            if (wr_ovf1) begin
                nxt[31:16] = nxt[31:16] & I_WDATA;
            end
            if (store_buf && full_q[win_dest]) begin
                nxt[win_dest] = 1'b1;
            end
            ovf_q <= nxt;
        end
    end

    // control registers with defined reset
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            filt_en_q <= `CAF_FILT_EN_RST;
            for (int i = 0; i < 4; i++) begin
                dest_q[i] <= 16'h0000;
            end
            msel_q[0] <= 16'h0000;
            msel_q[1] <= 16'h0000;
            int_en_q <= '0;
        end else if (I_WR) begin
            case (I_ADDR)
                `CAF_OFF_FILT_EN: filt_en_q <= I_WDATA;
                `CAF_OFF_DEST0: dest_q[0] <= I_WDATA;
                `CAF_OFF_DEST1: dest_q[1] <= I_WDATA;
                `CAF_OFF_DEST2: dest_q[2] <= I_WDATA;
                `CAF_OFF_DEST3: dest_q[3] <= I_WDATA;
                `CAF_OFF_MSEL0: msel_q[0] <= I_WDATA;
                `CAF_OFF_MSEL1: msel_q[1] <= I_WDATA;
                `CAF_OFF_INT_EN: int_en_q <= I_WDATA[`CAF_INT_W-1:0];
                default: ;
            endcase
        end
    end

    // identifier patterns and masks: no reset, software loads them
    always_ff @(posedge I_CLK) begin
        if (I_WR && I_ADDR >= `CAF_OFF_MASK_BASE && I_ADDR < `CAF_OFF_MASK_BASE + 8'h06) begin
            logic [7:0] k;
            k = I_ADDR - `CAF_OFF_MASK_BASE;
            if (k[0]) begin
                mask_eid_q[k[2:1]] <= I_WDATA;
            end else begin
                mask_sid_q[k[2:1]] <= I_WDATA & `CAF_SID_REG_MASK;
            end
        end
        if (I_WR && I_ADDR >= `CAF_OFF_FILT_BASE && I_ADDR <= `CAF_OFF_FILT_END) begin
            logic [7:0] k;
            k = I_ADDR - `CAF_OFF_FILT_BASE;
            if (k[0]) begin
                filt_eid_q[k[4:1]] <= I_WDATA;
            end else begin
                filt_sid_q[k[4:1]] <= I_WDATA & `CAF_SID_REG_MASK;
            end
        end
    end

    // interrupt status: events set, clear-register write clears, set wins
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            int_stat_q <= '0;
        end else begin
            logic [`CAF_INT_W-1:0] ev;
            ev = '0;
            ev[`CAF_INT_RX] = store_buf;
            ev[`CAF_INT_FIFO] = I_MSG_VALID && any_hit && to_fifo;
            ev[`CAF_INT_OVF] = store_buf && full_q[win_dest];
            ev[`CAF_INT_NOHIT] = I_MSG_VALID && !any_hit;
            if (I_WR && I_ADDR == `CAF_OFF_INT_CLR) begin
                int_stat_q <= (int_stat_q & ~I_WDATA[`CAF_INT_W-1:0]) | ev;
            end else begin
                int_stat_q <= int_stat_q | ev;
            end
        end
    end

    // routing outputs, registered
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ACCEPT <= 1'b0;
            O_REJECT <= 1'b0;
            O_ROUTE <= '0;
        end else begin
            O_ACCEPT <= I_MSG_VALID && any_hit;
            O_REJECT <= I_MSG_VALID && !any_hit;
            O_ROUTE.to_fifo <= to_fifo;
            O_ROUTE.buf_idx <= win_dest;
            O_ROUTE.filt_idx <= win;
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= 16'h0000;
        end else if (I_RD) begin
            logic [7:0] k;
            O_RDATA <= 16'h0000;
            k = I_ADDR;
            case (I_ADDR)
                `CAF_OFF_FILT_EN: O_RDATA <= filt_en_q;
                `CAF_OFF_DEST0: O_RDATA <= dest_q[0];
                `CAF_OFF_DEST1: O_RDATA <= dest_q[1];
                `CAF_OFF_DEST2: O_RDATA <= dest_q[2];
                `CAF_OFF_DEST3: O_RDATA <= dest_q[3];
                `CAF_OFF_MSEL0: O_RDATA <= msel_q[0];
                `CAF_OFF_MSEL1: O_RDATA <= msel_q[1];
                `CAF_OFF_FULL0: O_RDATA <= full_q[15:0];
                `CAF_OFF_FULL1: O_RDATA <= full_q[31:16];
                `CAF_OFF_OVF0: O_RDATA <= ovf_q[15:0];
                `CAF_OFF_OVF1: O_RDATA <= ovf_q[31:16];
                `CAF_OFF_INT_STAT: O_RDATA <= {12'h000, int_stat_q};
                `CAF_OFF_INT_EN: O_RDATA <= {12'h000, int_en_q};
                default: begin
                    if (k >= `CAF_OFF_MASK_BASE && k < `CAF_OFF_MASK_BASE + 8'h06) begin
                        k = k - `CAF_OFF_MASK_BASE;
                        O_RDATA <= k[0] ? mask_eid_q[k[2:1]] : mask_sid_q[k[2:1]];
                    end else if (k >= `CAF_OFF_FILT_BASE && k <= `CAF_OFF_FILT_END) begin
                        k = k - `CAF_OFF_FILT_BASE;
                        O_RDATA <= k[0] ? filt_eid_q[k[4:1]] : filt_sid_q[k[4:1]];
                    end
                end
            endcase
        end
    end

    // flag views and level interrupt
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_FULL <= '0;
            O_OVF <= '0;
            O_IRQ <= 1'b0;
        end else begin
            O_FULL <= full_q;
            O_OVF <= ovf_q;
            O_IRQ <= |(int_stat_q & int_en_q);
        end
    end
endmodule : caf_filter

`default_nettype wire

//--- rtl/caf_map.svh
// Purpose: register offsets, field positions and reset values of the acceptance filter
// Assumes: 16-bit registers on a plain word-addressed port
// Notes: definitions only
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH

`define CAF_ADDR_W 8
`define CAF_DATA_W 16
// filter enables, destinations and mask selects
`define CAF_OFF_FILT_EN 8'h00
`define CAF_OFF_DEST0 8'h01
`define CAF_OFF_DEST1 8'h02
`define CAF_OFF_DEST2 8'h03
`define CAF_OFF_DEST3 8'h04
`define CAF_OFF_MSEL0 8'h05
`define CAF_OFF_MSEL1 8'h06
// full and overflow flags
`define CAF_OFF_FULL0 8'h07
`define CAF_OFF_FULL1 8'h08
`define CAF_OFF_OVF0 8'h09
`define CAF_OFF_OVF1 8'h0a
// interrupt status, enable, clear
`define CAF_OFF_INT_STAT 8'h0b
`define CAF_OFF_INT_EN 8'h0c
`define CAF_OFF_INT_CLR 8'h0d
// mask n standard at 0x10+2n, extended at 0x11+2n
`define CAF_OFF_MASK_BASE 8'h10
// filter n standard at 0x20+2n, extended at 0x21+2n
`define CAF_OFF_FILT_BASE 8'h20
`define CAF_OFF_FILT_END 8'h3f
// standard-id register fields
`define CAF_SID_HI 15
`define CAF_SID_LO 5
`define CAF_TYPE_BIT 3
`define CAF_SID_REG_MASK 16'hffeb
// destination code for the fifo
`define CAF_DEST_FIFO 4'hf
`define CAF_MSK_RSVD 2'h3
`define CAF_FILT_EN_RST 16'hffff
// interrupt status bits
`define CAF_INT_RX 0
`define CAF_INT_FIFO 1
`define CAF_INT_OVF 2
`define CAF_INT_NOHIT 3
`define CAF_INT_W 4

`endif

//--- rtl/caf_pkg.sv
// Purpose: types shared by the acceptance filter
// Assumes: caf_map.svh holds the numbers
// Notes: none
package caf_pkg;
    // received message identifier as presented by the receive engine
    typedef struct packed {
        logic ext;
        logic [10:0] sid;
        logic [17:0] eid;
    } caf_msg_t;
    // routing result
    typedef struct packed {
        logic to_fifo;
        logic [3:0] buf_idx;
        logic [3:0] filt_idx;
    } caf_route_t;
    typedef enum logic [1:0] {
        CAF_MSK0,
        CAF_MSK1,
        CAF_MSK2,
        CAF_MSKR
    } caf_msk_sel_t;
endpackage : caf_pkg

//--- verif/caf_filter_asserts.sv
// Purpose: port checks of the acceptance filter
// Assumes: one clock, async active-low reset
// Notes: bound to every caf_filter
`timescale 1ns/10ps
`default_nettype none
module caf_filter_asserts #(
    parameter int NBUF = 32
) (
    // clock, reset and bus
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [15:0] O_RDATA,
    // message and flags
    input wire logic I_MSG_VALID,
    input wire logic O_ACCEPT,
    input wire logic O_REJECT,
    input wire caf_pkg::caf_route_t O_ROUTE,
    input wire logic [NBUF-1:0] O_FULL,
    input wire logic [NBUF-1:0] O_OVF
);
    import caf_pkg::*;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // one verdict per message, one cycle later
    property p_excl; !(O_ACCEPT && O_REJECT); endproperty
    a_excl: assert property (p_excl) else $error("accept with reject");
    property p_resp; I_MSG_VALID |=> O_ACCEPT ^ O_REJECT; endproperty
    a_resp: assert property (p_resp) else $error("no verdict");
    // flag views follow stores one edge behind the verdict
    property p_full; O_ACCEPT && !O_ROUTE.to_fifo |=> O_FULL[$past(O_ROUTE.buf_idx)]; endproperty
    a_full: assert property (p_full) else $error("full not set");
    property p_ovf;
        O_ACCEPT && !O_ROUTE.to_fifo && O_FULL[O_ROUTE.buf_idx] |=> O_OVF[$past(O_ROUTE.buf_idx)];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not set");
    property p_fcause; (O_FULL & ~$past(O_FULL)) != '0 |-> $past(O_ACCEPT); endproperty
    a_fcause: assert property (p_fcause) else $error("full set without store");
    property p_ocause;
        (O_OVF & ~$past(O_OVF)) != '0 |-> ($past(O_FULL) & O_OVF & ~$past(O_OVF)) != '0;
    endproperty
    a_ocause: assert property (p_ocause) else $error("overflow on empty buffer");
    // a zero write empties the low flags unless a message arrives in the same cycle
    property p_clr;
        I_WR && I_ADDR == 8'h07 && I_WDATA == 16'h0 && !I_MSG_VALID |-> ##2 O_FULL[15:0] == 16'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("full not cleared");
    property p_sid; I_RD && I_ADDR[7:5] == 3'h1 && !I_ADDR[0] |=> O_RDATA[4] == 1'h0 && O_RDATA[2] == 1'h0; endproperty
    a_sid: assert property (p_sid) else $error("unused id bits read set");
    // main scenarios
    c_rej: cover property (O_REJECT);
    c_fifo: cover property (O_ACCEPT && O_ROUTE.to_fifo);
    c_ovf: cover property (O_OVF != '0);
endmodule : caf_filter_asserts
bind caf_filter caf_filter_asserts #(.NBUF(NBUF)) caf_filter_asserts_inst (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_MSG_VALID(I_MSG_VALID), .O_ACCEPT(O_ACCEPT),
    .O_REJECT(O_REJECT), .O_ROUTE(O_ROUTE), .O_FULL(O_FULL), .O_OVF(O_OVF));
`default_nettype wire

//--- verif/caf_rx_engine.sv
// Purpose: receive engine stand-in feeding identifiers
// Assumes: bench raises i_go one cycle per message
// Notes: id lines toggle while idle
`timescale 1ns/10ps
`default_nettype none
module caf_rx_engine (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // request from the bench
    input wire logic i_go,
    input wire caf_pkg::caf_msg_t i_id,
    // towards the filter
    output logic o_valid,
    output caf_pkg::caf_msg_t o_msg
);
    import caf_pkg::*;
    // one-cycle strobe; idle ids change so stale ones never pass as fresh
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'h0;
            o_msg <= '0;
        end else begin
            o_valid <= i_go;
            o_msg <= i_go ? i_id : ~o_msg;
        end
    end
endmodule : caf_rx_engine
`default_nettype wire

//--- verif/caf_filter_tb.sv
// Purpose: self-checking bench of the acceptance filter
// Assumes: caf_rx_engine feeds identifiers
// Notes: notes queued at request, compared as answers appear
`timescale 1ns/10ps
`default_nettype none
module caf_filter_tb;
    import caf_pkg::*;
    logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, go = 0, rd_seen = 0;
    logic [7:0] addr = '0;
    logic [15:0] wdata = '0, rdata, en = 16'hffff, fl = '0, ov = '0, w, seen;
    logic [3:0] st = '0;
    logic [63:0] dw;
    logic [31:0] ms, full, ovf;
    logic [28:0] fid [16], mk [3];
    logic ft [16], mt [3], vld, acc, rej, irq;
    logic [1:0] sel [16];
    caf_msg_t id = '0, msg;
    caf_route_t route;
    logic [15:0] mq [$], rq [$];
    int err_total = 0, checks_done = 0;
    caf_rx_engine caf_rx_engine_inst (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_id(id),
        .o_valid(vld), .o_msg(msg));
    caf_filter caf_filter_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_en), .I_RD(rd_en), .O_RDATA(rdata), .I_MSG_VALID(vld), .I_MSG(msg),
        .O_ACCEPT(acc), .O_REJECT(rej), .O_ROUTE(route), .O_FULL(full), .O_OVF(ovf),
        .O_IRQ(irq));
    initial forever #10 clk = ~clk;
    task automatic chk(string s, logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", s, exp, got);
        end
    endtask : chk
    task automatic rw(logic wr, logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        wr_en <= wr;
        rd_en <= !wr;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 0;
        rd_en <= 0;
    endtask : rw
    task automatic rdx(logic [7:0] a, logic [15:0] exp);
        rq.push_back(exp);
        rw(0, a, 16'h0);
    endtask : rdx
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle
    // lowest enabled filter whose compared bits and frame kind agree
    function automatic logic [15:0] ref_route(caf_msg_t m);
        for (int f = 0; f < 16; f++)
            if (en[f] && !(mt[sel[f]] && ft[f] != m.ext) &&
                (({m.sid, m.eid} ^ fid[f]) & mk[sel[f]] & {11'h7ff, {18{m.ext}}}) == '0)
                return {5'h0, 2'h2, f == 15, 4'(f), 4'(f)};
        return 16'h0200;
    endfunction : ref_route
    // note the verdict and flag effects, then hand the id to the engine
    task automatic send(caf_msg_t m, bit gap);
        logic [15:0] r;
        r = ref_route(m);
        mq.push_back(r);
        st[3] |= !r[10];
        st[1] |= r[10] && r[8];
        if (r[10] && !r[8]) begin
            st[0] = 1;
            st[2] |= fl[r[7:4]];
            ov[r[7:4]] |= fl[r[7:4]];
            fl[r[7:4]] = 1;
        end
        @(posedge clk);
        go <= 1;
        id <= m;
        if (gap) begin
            @(posedge clk);
            go <= 0;
        end
    endtask : send
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // compare each answer with the oldest note
    always @(posedge clk) begin
        if (rd_seen)
            chk("rdata", rdata, rq.pop_front());
        seen = {5'h0, acc, rej, acc ? {route.to_fifo, route.to_fifo ? 4'hf : route.buf_idx,
            route.filt_idx} : 9'h0};
        if (acc || rej)
            chk("route", seen, mq.pop_front());
        rd_seen = rd_en;
    end
    initial begin
        caf_msg_t m;
        void'($urandom(32'h3918));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        // reset values; 0e and 0f are unmapped and read zero
        for (int a = 0; a < 16; a++)
            if (a != 13) rdx(8'(a), a == 0 ? 16'hffff : 16'h0);
        $display("reset test done");
        // masks: exact with type check, open, partial; filter 0 takes the open one
        mk = '{'1, '0, {11'h7f0, 18'h3ffff}};
        mt = '{1, 0, 0};
        for (int n = 0; n < 3; n++) begin
            rw(1, 8'(16 + 2 * n), {mk[n][28:18], 1'h0, mt[n], 1'h0, mk[n][17:16]});
            rw(1, 8'(17 + 2 * n), mk[n][15:0]);
        end
        for (int f = 0; f < 16; f++) begin
            fid[f] = 29'($urandom);
            ft[f] = 1'($urandom);
            sel[f] = f == 0 ? 2'h1 : 2'(f % 2) << 1;
            ms[2 * f +: 2] = sel[f];
            dw[4 * f +: 4] = 4'(f);
            rw(1, 8'(32 + 2 * f), {fid[f][28:18], 1'h0, ft[f], 1'h0, fid[f][17:16]});
            rw(1, 8'(33 + 2 * f), fid[f][15:0]);
        end
        for (int g = 0; g < 4; g++)
            rw(1, 8'(1 + g), dw[16 * g +: 16]);
        rw(1, 8'h05, ms[15:0]);
        rw(1, 8'h06, ms[31:16]);
        rdx(8'h22, {fid[1][28:18], 1'h0, ft[1], 1'h0, fid[1][17:16]});
        rdx(8'h04, dw[63:48]);
        rdx(8'h06, ms[31:16]);
        $display("config test done");
        // pass 0: filter 0 off; pass 1: filter 0 alone, so buffer 0 overflows
        for (int p = 0; p < 2; p++) begin
            en = p ? 16'h0001 : 16'hfffe;
            rw(1, 8'h00, en);
            for (int i = 0; i < 40; i++) begin
                m = {1'($urandom), 29'($urandom)};
                if (i < 16) m = {ft[i], fid[i]};
                send(m, i == 39 || $urandom % 3 == 0);
            end
            settle;
            chk("full view", full[15:0], fl);
            chk("ovf view", ovf[15:0], ov);
            rdx(8'h07, fl);
            rdx(8'h09, ov);
            w = p ? 16'h0 : 16'($urandom);
            rw(1, 8'h07, w);
            fl &= w;
            rw(1, 8'h09, 16'h0);
            ov = '0;
            rdx(8'h07, fl);
            rdx(8'h09, ov);
            $display("traffic pass %0d done", p);
        end
        // status, masked and enabled interrupt, clear
        rdx(8'h0b, {12'h0, st});
        settle;
        chk("masked irq", {15'h0, irq}, 16'h0);
        rw(1, 8'h0c, 16'h0004);
        settle;
        chk("irq", {15'h0, irq}, {15'h0, st[2]});
        rw(1, 8'h0d, 16'h000f);
        settle;
        chk("cleared irq", {15'h0, irq}, 16'h0);
        rdx(8'h0b, 16'h0);
        settle;
        chk("notes left", 16'(mq.size() + rq.size()), 16'h0);
        $display("interrupt test done");
        final_report;
    end
    // cut a hang short; the run needs under 2000 cycles
    initial begin
        #100000;
        err_total++;
        final_report;
    end
endmodule : caf_filter_tb
`default_nettype wire
